// [dv/sfg_guard_asserts.sv]
// Assertions on the guard's top ports.
// Assumes one clock domain; bound to every guard instance below.
`timescale 1ns/10ps
`default_nettype none

module sfg_guard_asserts
  import sfg_pkg::*;
#(
  parameter int FAULT_TOL  = 1,
  parameter int DC_WR_BACK = 0,
  parameter int TAG_W      = 20,
  parameter int IC_DW      = 32,
  parameter int DC_WORDS   = 4,
  parameter int IDX_W      = 8,
  parameter int XL_HI_W    = 32,
  parameter int XL_LO_W    = 32,
  parameter int XL_IDX_W   = 6,
  parameter int BT_W       = 32
) (
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire logic                   ic_hit_i,
  input wire logic [IDX_W-1:0]       ic_idx_i,
  input wire logic [TAG_W-1:0]       ic_rd_tag_i,
  input wire logic                   ic_rd_tag_par_i,
  input wire logic [IC_DW-1:0]       ic_rd_data_i,
  input wire logic                   ic_rd_data_par_i,
  input wire logic                   ic_inval_o,
  input wire logic [IDX_W-1:0]       ic_inval_idx_o,
  input wire logic                   dc_hit_i,
  input wire logic [TAG_W-1:0]       dc_rd_tag_i,
  input wire logic                   dc_rd_tag_par_i,
  input wire logic [DC_WORDS*32-1:0] dc_rd_words_i,
  input wire logic [DC_WORDS-1:0]    dc_rd_word_par_i,
  input wire logic                   dc_inval_o,
  input wire logic                   dc_write_through_o,
  input wire logic                   dc_cfg_reject_o,
  input wire logic                   xl_lookup_i,
  input wire logic                   xl_sw_rd_i,
  input wire logic [XL_IDX_W-1:0]    xl_idx_i,
  input wire logic [XL_HI_W-1:0]     xl_rd_hi_i,
  input wire logic [XL_LO_W-1:0]     xl_rd_lo_i,
  input wire logic                   xl_rd_par_i,
  input wire logic                   xl_miss_exc_o,
  input wire logic                   xl_clr_valid_o,
  input wire logic [XL_IDX_W-1:0]    xl_clr_idx_o,
  input wire logic                   bt_lookup_i,
  input wire logic [BT_W-1:0]        bt_rd_addr_i,
  input wire logic                   bt_rd_par_i,
  input wire logic                   bt_take_o,
  input wire logic [BT_W-1:0]        bt_tgt_o,
  input wire logic                   bt_discard_o,
  input wire logic                   ibus_ue_i,
  input wire logic                   dbus_ue_i,
  input wire logic                   exception_enable_bit_i,
  input wire logic                   exc_in_progress_i,
  input wire logic                   ibus_exc_o,
  input wire logic                   dbus_exc_o,
  input wire logic                   core_fault_halt_out_o
);
  // ****************************************************************
  // Helper terms: hits with odd stored parity
  // ****************************************************************
  logic ic_err;
  logic dc_err;
  logic [DC_WORDS-1:0] dc_wodd;
  always_comb begin
    for (int g = 0; g < DC_WORDS; g++) dc_wodd[g] = ^{dc_rd_words_i[g*32+:32], dc_rd_word_par_i[g]};
  end
  assign ic_err = ic_hit_i && (^{ic_rd_tag_i, ic_rd_tag_par_i} || ^{ic_rd_data_i, ic_rd_data_par_i});
  assign dc_err = dc_hit_i && (^{dc_rd_tag_i, dc_rd_tag_par_i} || (|dc_wodd));

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence xl_bad;
    ^{xl_rd_hi_i, xl_rd_lo_i, xl_rd_par_i};
  endsequence
  sequence bt_bad;
    bt_lookup_i && ^{bt_rd_addr_i, bt_rd_par_i};
  endsequence
  sequence bt_good;
    bt_lookup_i && !(^{bt_rd_addr_i, bt_rd_par_i});
  endsequence
  // Enabled, idle and not stopped
  sequence exc_free;
    exception_enable_bit_i && !exc_in_progress_i && !ibus_exc_o && !dbus_exc_o && !core_fault_halt_out_o;
  endsequence
  sequence exc_nested;
    (exc_in_progress_i || ibus_exc_o || dbus_exc_o) && (ibus_ue_i || dbus_ue_i);
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ic_bad_inval: assert property (ic_err |=> ic_inval_o && ic_inval_idx_o == $past(ic_idx_i))
    else $error("icache line kept after bad hit");
  a_ic_no_spurious: assert property (ic_inval_o |-> $past(ic_err))
    else $error("icache invalidate without bad hit");
  a_dc_bad_inval: assert property (dc_err |=> dc_inval_o)
    else $error("dcache line kept after bad hit");
  a_dc_mode_fixed: assert property (dc_write_through_o == (FAULT_TOL != 0 || DC_WR_BACK == 0)
    && dc_cfg_reject_o == (FAULT_TOL != 0 && DC_WR_BACK != 0))
    else $error("dcache write mode wrong");
  a_xl_miss_exc: assert property (xl_lookup_i ##0 xl_bad |=> xl_miss_exc_o)
    else $error("no miss on bad entry");
  a_xl_clr_valid: assert property (xl_sw_rd_i ##0 xl_bad |=> xl_clr_valid_o && xl_clr_idx_o == $past(xl_idx_i))
    else $error("bad entry read kept valid");
  a_bt_discard: assert property (bt_bad |=> bt_discard_o && !bt_take_o && $stable(bt_tgt_o))
    else $error("bad target not dropped");
  a_bt_take: assert property (bt_good |=> bt_take_o && !bt_discard_o && bt_tgt_o == $past(bt_rd_addr_i))
    else $error("good target not used");
  a_ibus_exc: assert property (exc_free ##0 ibus_ue_i |=> ibus_exc_o && !dbus_exc_o)
    else $error("ibus error gave no exception");
  a_dbus_exc: assert property (exc_free ##0 dbus_ue_i && !ibus_ue_i |=> dbus_exc_o)
    else $error("dbus error gave no exception");
  a_nested_halt: assert property (exc_nested |=> core_fault_halt_out_o)
    else $error("nested exception did not halt");
  a_halt_sticky: assert property (core_fault_halt_out_o |=> core_fault_halt_out_o && !ibus_exc_o && !dbus_exc_o)
    else $error("halt dropped or pulse after halt");
endmodule

bind sfg_guard sfg_guard_asserts #(.FAULT_TOL(FAULT_TOL), .DC_WR_BACK(DC_WR_BACK), .TAG_W(TAG_W), .IC_DW(IC_DW),
  .DC_WORDS(DC_WORDS), .IDX_W(IDX_W), .XL_HI_W(XL_HI_W), .XL_LO_W(XL_LO_W), .XL_IDX_W(XL_IDX_W), .BT_W(BT_W)) u_chk (.*);

`default_nettype wire

// [dv/sfg_guard_bench.sv]
// Self-checking bench for the guard, default widths.
// Assumes the memory model and bound checker are compiled too.
`timescale 1ns/10ps
`default_nettype none

module soft_core_parity_fault_guard_bench;
  import sfg_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1;
  logic [19:0] ic_tag_i, ic_rd_tag_i, dc_tag_i, dc_rd_tag_i;
  logic [31:0] ic_data_i, ic_rd_data_i, xl_rd_hi_i, xl_rd_lo_i, bt_addr_i, bt_rd_addr_i, bt_tgt_o;
  logic [31:0] xlate_entry_high_reg_i, xlate_entry_low_reg_i;
  logic [127:0] dc_words_i, dc_rd_words_i;
  logic [7:0] ic_idx_i, dc_idx_i, ic_inval_idx_o, dc_inval_idx_o;
  logic [5:0] xl_idx_i, xl_clr_idx_o;
  logic [3:0] dc_rd_word_par_i, dc_word_par_o;
  logic ic_tag_par_o, ic_data_par_o, ic_hit_i, ic_rd_tag_par_i, ic_rd_data_par_i, ic_inval_o;
  logic dc_tag_par_o, dc_hit_i, dc_rd_tag_par_i, dc_inval_o, dc_write_through_o, dc_cfg_reject_o;
  logic xl_par_o, xl_lookup_i, xl_sw_rd_i, xl_rd_par_i, xl_miss_exc_o, xl_clr_valid_o;
  logic bt_par_o, bt_lookup_i, bt_rd_par_i, bt_take_o, bt_discard_o;
  logic ibus_ue_i, dbus_ue_i, exception_enable_bit_i, exc_in_progress_i, ibus_exc_o, dbus_exc_o;
  logic core_fault_halt_out_o, err_side;
  logic [1:0] err_kind;
  logic e_ic, e_dc, e_miss, e_clr, e_take, e_disc, xbad, bbad;
  logic [7:0] e_ic_idx, e_dc_idx;
  logic [5:0] e_clr_idx;
  logic [31:0] e_tgt;
  int mismatches = 0;
  int n_checks = 0;

  sfg_guard dut (.*);
  sfg_lmb_model u_lmb (.clk_i(clk_i), .reset_i(reset_i), .err_kind_i(err_kind), .err_side_i(err_side),
                       .ibus_ue_o(ibus_ue_i), .dbus_ue_o(dbus_ue_i));

  always #5 clk_i = ~clk_i;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [3:0] wpar(input logic [127:0] w);
    logic [3:0] p;
    for (int g = 0; g < 4; g++) p[g] = ^w[g*32+:32];
    return p;
  endfunction
  // One field in four gets bad parity
  function automatic logic sick();
    return $urandom_range(3) == 0;
  endfunction
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
  endtask
  task automatic drive_rand();
    {ic_tag_i, dc_tag_i, ic_rd_tag_i, dc_rd_tag_i} = {$urandom, $urandom, 16'($urandom)};
    {ic_data_i, ic_rd_data_i, bt_addr_i, bt_rd_addr_i} = {$urandom, $urandom, $urandom, $urandom};
    {xlate_entry_high_reg_i, xlate_entry_low_reg_i, xl_rd_hi_i, xl_rd_lo_i} = {$urandom, $urandom, $urandom, $urandom};
    dc_words_i = {$urandom, $urandom, $urandom, $urandom};
    dc_rd_words_i = {$urandom, $urandom, $urandom, $urandom};
    {ic_hit_i, dc_hit_i, xl_lookup_i, xl_sw_rd_i, bt_lookup_i, ic_idx_i, dc_idx_i, xl_idx_i} = 27'($urandom);
    ic_rd_tag_par_i = ^ic_rd_tag_i ^ sick();
    ic_rd_data_par_i = ^ic_rd_data_i ^ sick();
    dc_rd_tag_par_i = ^dc_rd_tag_i ^ sick();
    dc_rd_word_par_i = wpar(dc_rd_words_i) ^ {sick(), sick(), sick(), sick()};
    xl_rd_par_i = ^{xl_rd_hi_i, xl_rd_lo_i} ^ sick();
    bt_rd_par_i = ^bt_rd_addr_i ^ sick();
  endtask
  // Expected outcome one edge later
  task automatic predict();
    e_ic = ic_hit_i && (^{ic_rd_tag_i, ic_rd_tag_par_i} || ^{ic_rd_data_i, ic_rd_data_par_i});
    e_dc = dc_hit_i && (^{dc_rd_tag_i, dc_rd_tag_par_i} || wpar(dc_rd_words_i) != dc_rd_word_par_i);
    if (e_ic) e_ic_idx = ic_idx_i;
    if (e_dc) e_dc_idx = dc_idx_i;
    xbad = ^{xl_rd_hi_i, xl_rd_lo_i, xl_rd_par_i};
    {e_miss, e_clr} = {xl_lookup_i && xbad, xl_sw_rd_i && xbad};
    if (e_clr) e_clr_idx = xl_idx_i;
    bbad = ^{bt_rd_addr_i, bt_rd_par_i};
    {e_take, e_disc} = {bt_lookup_i && !bbad, bt_lookup_i && bbad};
    if (e_take) e_tgt = bt_rd_addr_i;
  endtask
  // Fault held len cycles on one side; outcome {ibus exc, dbus exc, halt}
  task automatic exc_case(input logic en, busy, input logic [1:0] kind, input logic side, input int len,
                          input logic [2:0] exp);
    @(negedge clk_i);
    {exception_enable_bit_i, exc_in_progress_i, err_kind, err_side} = {en, busy, kind, side};
    repeat (len) @(negedge clk_i);
    err_kind = 2'h0;
    @(negedge clk_i);
    chk("exc_outcome", 64'(exp), 64'({ibus_exc_o, dbus_exc_o, core_fault_halt_out_o}));
    exc_in_progress_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("halt_hold", 64'(exp[0]), 64'(core_fault_halt_out_o));
    if (exp[0]) do_reset();
    $display("exc case done kind %0d side %0d", kind, side);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(16));
    drive_rand();
    {ic_hit_i, dc_hit_i, xl_lookup_i, xl_sw_rd_i, bt_lookup_i} = 5'h0;
    {exception_enable_bit_i, exc_in_progress_i, err_kind, err_side} = 5'h0;
    {e_ic, e_dc, e_miss, e_clr, e_take, e_disc, e_ic_idx, e_dc_idx, e_clr_idx, e_tgt} = '0;
    do_reset();
    chk("dc_mode", 64'h2, 64'({dc_write_through_o, dc_cfg_reject_o}));
    // Random hits, lookups and writes; hits and lookups checked one edge later, writes at once
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_i);
      chk("ic_inval", {e_ic_idx, e_ic}, {ic_inval_idx_o, ic_inval_o});
      chk("dc_inval", {e_dc_idx, e_dc}, {dc_inval_idx_o, dc_inval_o});
      chk("xl_miss", 64'(e_miss), 64'(xl_miss_exc_o));
      chk("xl_clr", {e_clr_idx, e_clr}, {xl_clr_idx_o, xl_clr_valid_o});
      chk("bt_result", {e_tgt, e_take, e_disc}, {bt_tgt_o, bt_take_o, bt_discard_o});
      drive_rand();
      predict();
      #1;
      chk("ic_par", {^ic_tag_i, ^ic_data_i}, {ic_tag_par_o, ic_data_par_o});
      chk("dc_par", {^dc_tag_i, wpar(dc_words_i)}, {dc_tag_par_o, dc_word_par_o});
      chk("xl_par", 64'(^{xlate_entry_high_reg_i, xlate_entry_low_reg_i}), 64'(xl_par_o));
      chk("bt_par", 64'(^bt_addr_i), 64'(bt_par_o));
    end
    {ic_hit_i, dc_hit_i, xl_lookup_i, xl_sw_rd_i, bt_lookup_i} = 5'h0;
    $display("random parity test done");
    exc_case(1'b1, 1'b0, 2'h2, 1'b0, 1, 3'h4);
    exc_case(1'b1, 1'b0, 2'h2, 1'b1, 1, 3'h2);
    exc_case(1'b1, 1'b0, 2'h1, 1'b1, 1, 3'h0);
    exc_case(1'b0, 1'b0, 2'h2, 1'b0, 1, 3'h0);
    exc_case(1'b1, 1'b1, 2'h2, 1'b1, 1, 3'h1);
    exc_case(1'b1, 1'b0, 2'h2, 1'b0, 2, 3'h1);
    exc_case(1'b1, 1'b0, 2'h2, 1'b1, 1, 3'h2);
    summarize();
  end

  // Hang guard, far past the tests' few hundred cycles
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule

`default_nettype wire

// [dv/sfg_lmb_model.sv]
// Local memory bus ECC controller model feeding the error inputs.
// Assumes the bench picks the fault kind and bus side one cycle ahead.
`timescale 1ns/10ps
`default_nettype none

module sfg_lmb_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] err_kind_i,  // 0 clean, 1 single bit, 2 double bit
  input  wire logic       err_side_i,  // 0 instruction, 1 data
  output logic            ibus_ue_o,
  output logic            dbus_ue_o
);
  // ****************************************************************
  // Error indications
  // ****************************************************************
  // Single-bit faults are repaired first and raise nothing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ibus_ue_o <= 1'b0;
      dbus_ue_o <= 1'b0;
    end else begin
      ibus_ue_o <= (err_kind_i == 2'h2) && !err_side_i;
      dbus_ue_o <= (err_kind_i == 2'h2) && err_side_i;
    end
  end
endmodule

`default_nettype wire

// [verilog/sfg_exc_ctl.sv]
// Turns local memory uncorrectable errors into bus exceptions.
// Assumes error indications are synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none

module sfg_exc_ctl
  import sfg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  sfg_exc_if.ctl    exc
);

  sfg_state_t state_ff;
  sfg_state_t nxt_state;
  logic       ibus_exc_ff;
  logic       dbus_exc_ff;
  logic       busy;
  logic       any_ue;

  // A raise from last cycle counts as in progress before the core sees it
  assign busy   = exc.in_exc | ibus_exc_ff | dbus_exc_ff;
  assign any_ue = exc.ibus_ue | exc.dbus_ue;

  // ****************************************************************
  // Run or halt
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SFG_RUN: begin
        if (any_ue && busy) begin
          nxt_state = SFG_HALT;
        end
      end
      SFG_HALT: nxt_state = SFG_HALT;  // Only reset leaves halt
      default:  nxt_state = SFG_HALT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= SFG_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Exception pulses, instruction side wins a tie
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ibus_exc_ff <= `SFG_RST_PULSE;
      dbus_exc_ff <= `SFG_RST_PULSE;
    end else begin
      ibus_exc_ff <= (state_ff == SFG_RUN) && !busy && exc.exc_en
                     && exc.ibus_ue;
      dbus_exc_ff <= (state_ff == SFG_RUN) && !busy && exc.exc_en
                     && !exc.ibus_ue && exc.dbus_ue;
    end
  end

  assign exc.ibus_exc = ibus_exc_ff;
  assign exc.dbus_exc = dbus_exc_ff;
  assign exc.halt     = (state_ff == SFG_HALT);
endmodule

`default_nettype wire

// [verilog/sfg_exc_if.sv]
// Carrier between the guard top and its exception controller.
// Assumes both ends run on the same processor clock.
`timescale 1ns/10ps
`default_nettype none

interface sfg_exc_if;
  logic ibus_ue;   // Uncorrectable error, instruction side
  logic dbus_ue;   // Uncorrectable error, data side
  logic exc_en;    // Exception enable bit of the core
  logic in_exc;    // Core is inside an exception handler
  logic ibus_exc;  // Raise instruction bus exception
  logic dbus_exc;  // Raise data bus exception
  logic halt;      // Core stop and external error level

  modport src (output ibus_ue, dbus_ue, exc_en, in_exc,
               input  ibus_exc, dbus_exc, halt);
  modport ctl (input  ibus_ue, dbus_ue, exc_en, in_exc,
               output ibus_exc, dbus_exc, halt);
endinterface

`default_nettype wire

// [verilog/sfg_guard.sv]
// Parity fault guard for the internal RAMs of a soft core.
// Assumes the caches, translation buffer and branch target cache
// keep the parity bits given here and return them on every read.
`timescale 1ns/10ps
`default_nettype none

module sfg_guard
  import sfg_pkg::*;
#(
  parameter int FAULT_TOL  = 1,
  parameter int DC_WR_BACK = 0,
  parameter int TAG_W      = 20,
  parameter int IC_DW      = 32,
  parameter int DC_WORDS   = 4,
  parameter int IDX_W      = 8,
  parameter int XL_HI_W    = 32,
  parameter int XL_LO_W    = 32,
  parameter int XL_IDX_W   = 6,
  parameter int BT_W       = 32
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // Instruction cache write side
  input  wire logic [TAG_W-1:0]       ic_tag_i,
  input  wire logic [IC_DW-1:0]       ic_data_i,
  output logic                        ic_tag_par_o,
  output logic                        ic_data_par_o,
  // Instruction cache hit side
  input  wire logic                   ic_hit_i,
  input  wire logic [IDX_W-1:0]       ic_idx_i,
  input  wire logic [TAG_W-1:0]       ic_rd_tag_i,
  input  wire logic                   ic_rd_tag_par_i,
  input  wire logic [IC_DW-1:0]       ic_rd_data_i,
  input  wire logic                   ic_rd_data_par_i,
  output logic                        ic_inval_o,
  output logic [IDX_W-1:0]            ic_inval_idx_o,
  // Data cache write side
  input  wire logic [TAG_W-1:0]       dc_tag_i,
  input  wire logic [DC_WORDS*32-1:0] dc_words_i,
  output logic                        dc_tag_par_o,
  output logic [DC_WORDS-1:0]         dc_word_par_o,
  // Data cache hit side
  input  wire logic                   dc_hit_i,
  input  wire logic [IDX_W-1:0]       dc_idx_i,
  input  wire logic [TAG_W-1:0]       dc_rd_tag_i,
  input  wire logic                   dc_rd_tag_par_i,
  input  wire logic [DC_WORDS*32-1:0] dc_rd_words_i,
  input  wire logic [DC_WORDS-1:0]    dc_rd_word_par_i,
  output logic                        dc_inval_o,
  output logic [IDX_W-1:0]            dc_inval_idx_o,
  output logic                        dc_write_through_o,
  output logic                        dc_cfg_reject_o,
  // Translation buffer, entry registers and lookup
  input  wire logic [XL_HI_W-1:0]     xlate_entry_high_reg_i,
  input  wire logic [XL_LO_W-1:0]     xlate_entry_low_reg_i,
  output logic                        xl_par_o,
  input  wire logic                   xl_lookup_i,
  input  wire logic                   xl_sw_rd_i,
  input  wire logic [XL_IDX_W-1:0]    xl_idx_i,
  input  wire logic [XL_HI_W-1:0]     xl_rd_hi_i,
  input  wire logic [XL_LO_W-1:0]     xl_rd_lo_i,
  input  wire logic                   xl_rd_par_i,
  output logic                        xl_miss_exc_o,
  output logic                        xl_clr_valid_o,
  output logic [XL_IDX_W-1:0]         xl_clr_idx_o,
  // Branch target cache
  input  wire logic [BT_W-1:0]        bt_addr_i,
  output logic                        bt_par_o,
  input  wire logic                   bt_lookup_i,
  input  wire logic [BT_W-1:0]        bt_rd_addr_i,
  input  wire logic                   bt_rd_par_i,
  output logic                        bt_take_o,
  output logic [BT_W-1:0]             bt_tgt_o,
  output logic                        bt_discard_o,
  // Local memory bus error indications and core status
  input  wire logic                   ibus_ue_i,
  input  wire logic                   dbus_ue_i,
  input  wire logic                   exception_enable_bit_i,
  input  wire logic                   exc_in_progress_i,
  output logic                        ibus_exc_o,
  output logic                        dbus_exc_o,
  output logic                        core_fault_halt_out_o
);

  localparam logic FT_ON = (FAULT_TOL != 0);

  logic                ic_tag_err;
  logic                ic_data_err;
  logic                dc_tag_err;
  logic [DC_WORDS-1:0] dc_word_err;
  logic                xl_err;
  logic                bt_err;
  logic                xl_chk;

  // ****************************************************************
  // Instruction cache parity
  // ****************************************************************
  // Tag and data checked apart; either spoils the line
  sfg_par_chk #(.W(TAG_W)) u_ic_tag (
    .wr_data_i (ic_tag_i),
    .wr_par_o  (ic_tag_par_o),
    .chk_en_i  (ic_hit_i && FT_ON),
    .rd_data_i (ic_rd_tag_i),
    .rd_par_i  (ic_rd_tag_par_i),
    .err_o     (ic_tag_err)
  );

  sfg_par_chk #(.W(IC_DW)) u_ic_data (
    .wr_data_i (ic_data_i),
    .wr_par_o  (ic_data_par_o),
    .chk_en_i  (ic_hit_i && FT_ON),
    .rd_data_i (ic_rd_data_i),
    .rd_par_i  (ic_rd_data_par_i),
    .err_o     (ic_data_err)
  );

  // ****************************************************************
  // Data cache parity, one bit per word
  // ****************************************************************
  sfg_par_chk #(.W(TAG_W)) u_dc_tag (
    .wr_data_i (dc_tag_i),
    .wr_par_o  (dc_tag_par_o),
    .chk_en_i  (dc_hit_i && FT_ON),
    .rd_data_i (dc_rd_tag_i),
    .rd_par_i  (dc_rd_tag_par_i),
    .err_o     (dc_tag_err)
  );

  // A per-word bit keeps partial word writes cheap to re-protect
  for (genvar g = 0; g < DC_WORDS; g++) begin : g_dc_word
    sfg_par_chk #(.W(32)) u_dc_word (
      .wr_data_i (dc_words_i[g*32 +: 32]),
      .wr_par_o  (dc_word_par_o[g]),
      .chk_en_i  (dc_hit_i && FT_ON),
      .rd_data_i (dc_rd_words_i[g*32 +: 32]),
      .rd_par_i  (dc_rd_word_par_i[g]),
      .err_o     (dc_word_err[g])
    );
  end

  // ****************************************************************
  // Translation buffer parity, one bit per entry
  // ****************************************************************
  // One check serves lookup and software read
  assign xl_chk = (xl_lookup_i || xl_sw_rd_i) && FT_ON;

  sfg_par_chk #(.W(XL_HI_W + XL_LO_W)) u_xl (
    .wr_data_i ({xlate_entry_high_reg_i, xlate_entry_low_reg_i}),
    .wr_par_o  (xl_par_o),
    .chk_en_i  (xl_chk),
    .rd_data_i ({xl_rd_hi_i, xl_rd_lo_i}),
    .rd_par_i  (xl_rd_par_i),
    .err_o     (xl_err)
  );

  // ****************************************************************
  // Branch target cache parity, one bit per address
  // ****************************************************************
  sfg_par_chk #(.W(BT_W)) u_bt (
    .wr_data_i (bt_addr_i),
    .wr_par_o  (bt_par_o),
    .chk_en_i  (bt_lookup_i && FT_ON),
    .rd_data_i (bt_rd_addr_i),
    .rd_par_i  (bt_rd_par_i),
    .err_o     (bt_err)
  );

  // ****************************************************************
  // Cache line invalidation
  // ****************************************************************
  // One-cycle pulse with the index of the hit that failed
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ic_inval_o     <= `SFG_RST_PULSE;
      ic_inval_idx_o <= '0;
    end else begin
      ic_inval_o <= ic_tag_err || ic_data_err;
      if (ic_tag_err || ic_data_err) begin
        ic_inval_idx_o <= ic_idx_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dc_inval_o     <= `SFG_RST_PULSE;
      dc_inval_idx_o <= '0;
    end else begin
      dc_inval_o <= dc_tag_err || (|dc_word_err);
      if (dc_tag_err || (|dc_word_err)) begin
        dc_inval_idx_o <= dc_idx_i;
      end
    end
  end

  // ****************************************************************
  // Data cache write policy
  // ****************************************************************
  // Invalidate-and-refetch loses dirty data, so write-back cannot stand
  assign dc_cfg_reject_o    = FT_ON && (DC_WR_BACK != 0);
  assign dc_write_through_o = FT_ON || (DC_WR_BACK == 0);

  // ****************************************************************
  // Translation buffer reactions
  // ****************************************************************
  // Lookup failure becomes a miss so software reloads the entry
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xl_miss_exc_o <= `SFG_RST_PULSE;
    end else begin
      xl_miss_exc_o <= xl_err && xl_lookup_i;
    end
  end

  // Software read failure drops the valid bit of that entry
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xl_clr_valid_o <= `SFG_RST_PULSE;
      xl_clr_idx_o   <= '0;
    end else begin
      xl_clr_valid_o <= xl_err && xl_sw_rd_i;
      if (xl_err && xl_sw_rd_i) begin
        xl_clr_idx_o <= xl_idx_i;
      end
    end
  end

  // ****************************************************************
  // Branch prediction filter
  // ****************************************************************
  // A bad target is never used; the branch takes the slow path
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bt_take_o    <= `SFG_RST_PULSE;
      bt_discard_o <= `SFG_RST_PULSE;
      bt_tgt_o     <= '0;
    end else begin
      bt_take_o    <= bt_lookup_i && !bt_err;
      bt_discard_o <= bt_err;
      if (bt_lookup_i && !bt_err) begin
        bt_tgt_o <= bt_rd_addr_i;
      end
    end
  end

  // ****************************************************************
  // Bus exceptions and halt
  // ****************************************************************
  sfg_exc_if exc_if ();

  // Controller errors are trusted as uncorrectable only
  assign exc_if.ibus_ue = ibus_ue_i && FT_ON;
  assign exc_if.dbus_ue = dbus_ue_i && FT_ON;
  assign exc_if.exc_en  = exception_enable_bit_i;
  assign exc_if.in_exc  = exc_in_progress_i;

  sfg_exc_ctl u_exc (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .exc     (exc_if.ctl)
  );

  assign ibus_exc_o            = exc_if.ibus_exc;
  assign dbus_exc_o            = exc_if.dbus_exc;
  assign core_fault_halt_out_o = exc_if.halt;
endmodule

`default_nettype wire

// [verilog/sfg_guard_map.svh]
// Constant map for the parity fault guard.
// Assumes inclusion by bare name.
`ifndef SFG_GUARD_MAP_SVH
`define SFG_GUARD_MAP_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define SFG_RST_PULSE  1'b0
`define SFG_RST_HALT   1'b0

// ****************************************************************
// Parity sense: even
// ****************************************************************
`define SFG_PAR_OK     1'b0

// ****************************************************************
// State codes of the exception controller, one-hot
// ****************************************************************
`define SFG_ST_RUN     2'h1
`define SFG_ST_HALT    2'h2

`endif

// [verilog/sfg_par_chk.sv]
// Even parity generator and checker for one protected field.
// Assumes stored parity returns beside the data it was made for.
`timescale 1ns/10ps
`default_nettype none

module sfg_par_chk
  import sfg_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic [W-1:0] wr_data_i,
  output logic              wr_par_o,
  input  wire logic         chk_en_i,
  input  wire logic [W-1:0] rd_data_i,
  input  wire logic         rd_par_i,
  output logic              err_o
);

  // Even parity bit over a field
  function automatic logic even_par(input logic [W-1:0] d);
    even_par = ^d;
  endfunction

  // Parity is ready in the write cycle, no pipeline stage
  assign wr_par_o = even_par(wr_data_i);

  // Mismatch counts only on a qualified read
  assign err_o = chk_en_i &
                 ((even_par(rd_data_i) ^ rd_par_i) != `SFG_PAR_OK);
endmodule

`default_nettype wire

// [verilog/sfg_pkg.sv]
// Types shared by the parity fault guard modules.
// Assumes the constant map header sits in the include path.
`include "sfg_guard_map.svh"

package sfg_pkg;

  // ****************************************************************
  // Exception controller states
  // ****************************************************************
  typedef enum logic [1:0] {
    SFG_RUN  = `SFG_ST_RUN,
    SFG_HALT = `SFG_ST_HALT
  } sfg_state_t;

endpackage
